// ===== hdl/dcp_pkg.sv
package dcp_pkg;

   // Register byte addresses on the plain register port
   localparam logic [7:0] ADDR_XTR_FOUR = 8'h57;
   localparam logic [7:0] ADDR_XTR_FIVE = 8'h58;
   localparam logic [7:0] ADDR_XTR_SIX = 8'h59;
   localparam logic [7:0] ADDR_PERIOD = 8'h5C;
   localparam logic [7:0] ADDR_SW_DELAY = 8'h5D;
   localparam logic [7:0] ADDR_PULSE_WIDTH = 8'h5E;

   // Reset values
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] SW_DELAY_RESET = 8'h14;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Field positions
   localparam int PERIOD_HI_BIT = 7;
   localparam int PERIOD_FIXED_BIT = 6;
   localparam int PERIOD_LO_MSB = 5;
   localparam int CAL_BIT = 7;
   localparam int RSVD_BIT = 6;
   localparam int POL_BIT = 5;
   localparam int MIN_OFF_MSB = 4;
   localparam int MIN_OFF_W = 5;

   // Fixed part of the minimum off time, in ticks
   localparam logic [7:0] MIN_OFF_BASE = 8'h04;
   localparam logic [7:0] TICK_ONE = 8'h01;
   localparam logic [7:0] TICK_ZERO = 8'h00;

   // Timing: one tick is 61.035 ns, clock is 4 ns
   localparam real TICK_NS = 61.035;
   localparam real CLK_NS = 4.0;
   localparam int NCO_W = 16;
   localparam int NCO_INC_I = int'((CLK_NS * (2.0 ** NCO_W)) / TICK_NS);
   localparam logic [NCO_W-1:0] NCO_INC = NCO_INC_I[NCO_W-1:0];
   localparam logic [NCO_W-1:0] NCO_RESET = 16'h0000;

   // Calibration length counter width
   localparam int CAL_CNT_W = 16;

   // Number of current sense channels
   localparam int NUM_XTR = 3;

   typedef enum logic [1:0] {
      DCP_ST_OFF,
      DCP_ST_ON,
      DCP_ST_CAL
   } dcp_state_t;

endpackage

// ===== hdl/dcp_tick_gen.sv
`timescale 1ns/1ps
module dcp_tick_gen
   import dcp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Tick enable, one cycle per 61.035 ns on average
   output logic tick_en_ff
);

   logic [NCO_W-1:0] acc_ff;
   logic [NCO_W:0] nxt_sum;

   // Fractional divider; jitter of one clock beats a 15-or-16 cycle drift
   always_comb begin
      nxt_sum = {1'b0, acc_ff} + {1'b0, NCO_INC};
   end

   // Accumulator and carry-out as the tick
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         acc_ff <= NCO_RESET;
         tick_en_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_sum[NCO_W-1:0];
         tick_en_ff <= nxt_sum[NCO_W];
      end
   end

endmodule

// ===== hdl/dcp_top.sv
`timescale 1ns/1ps
// Functional notes
// - Transistor four current is an 8-bit read-only live value.
// - Transistor five current is an 8-bit read-only live value.
// - Transistor six current is read-only with five's scaling.
// - Switching period is the period code times one tick.
// - Period bit six reads one and ignores writes.
// - Writing one to switching-delay bit seven starts calibration; a one written mid-run is ignored except in the run's last cycle, where it restarts the run.
// - The calibration bit reads one while calibration runs.
// - Bit five reports fixed feed-forward polarity of the variant.
// - Drive stays off at least minimum-off code plus four ticks.
// - Pulse-width code minus off code minus four gives on ticks.
module dcp_top
   import dcp_pkg::*;
#(
   // Feed-forward polarity of this variant: 0 opposite, 1 same
   parameter logic FF_SAME_POLARITY = 1'b0,
   // Length of the peak-current-monitor calibration, in ticks
   parameter logic [CAL_CNT_W-1:0] CAL_TICKS = 16'h0400
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   // Live transistor current codes from the sense converter
   input wire logic [7:0] xtr_four_current_in,
   input wire logic [7:0] xtr_five_current_in,
   input wire logic [7:0] xtr_six_current_in,
   // Pulse width demand from the regulation loop
   input wire logic [7:0] pw_demand,
   // Converter pins
   output logic converter_drive_out_ff,
   output logic feedforward_pin_ff,
   // Calibration in progress, for the peak current monitor
   output logic peak_monitor_cal_ff
);

   // Software registers
   logic [7:0] converter_period_code_ff;
   logic [MIN_OFF_W-1:0] min_off_code_ff;

   // Values that hold for the running period
   logic [7:0] act_period_ff;
   logic [7:0] act_on_ff;
   logic [7:0] pulse_width_code_ff;

   // Sequencing
   dcp_state_t state_ff;
   dcp_state_t nxt_state;
   logic [7:0] tick_cnt_ff;
   logic [7:0] nxt_tick_cnt;
   logic [CAL_CNT_W-1:0] cal_cnt_ff;
   logic tick_en;

   // Decoded bus and sequence events
   logic wr_period;
   logic wr_delay;
   logic cal_done;
   logic cal_start;
   logic period_end;
   logic on_end;

   // Clamp of the demand into the legal window
   logic [7:0] off_ticks;
   logic [7:0] nxt_pw;
   logic [7:0] nxt_on;

   // Current readback
   logic [7:0] xtr_in [NUM_XTR];
   logic [7:0] xtr_current_ff [NUM_XTR];
   logic [7:0] rd_mux;

   // Tick source
   dcp_tick_gen u_tick (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tick_en_ff(tick_en)
   );

   // Bus decode
   assign wr_period = reg_wr && (reg_addr == ADDR_PERIOD);
   assign wr_delay = reg_wr && (reg_addr == ADDR_SW_DELAY);

   // Period code: bit six is tied high in storage as well as on read
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         converter_period_code_ff <= PERIOD_RESET;
      end else if (wr_period) begin
         converter_period_code_ff <= {reg_wdata[PERIOD_HI_BIT], 1'b1,
            reg_wdata[PERIOD_LO_MSB:0]};
      end
   end

   // Minimum off code; polarity and reserved bits are not stored
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         min_off_code_ff <= SW_DELAY_RESET[MIN_OFF_MSB:0];
      end else if (wr_delay) begin
         min_off_code_ff <= reg_wdata[MIN_OFF_MSB:0];
      end
   end

   // Calibration request; a new start in the last cycle wins over done
   assign cal_done = (state_ff == DCP_ST_CAL) && tick_en &&
      (cal_cnt_ff == CAL_TICKS - 16'h0001);
   assign cal_start = wr_delay && reg_wdata[CAL_BIT] &&
      (!peak_monitor_cal_ff || cal_done);

   // Calibration status flag
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         peak_monitor_cal_ff <= 1'b0;
      end else if (cal_start) begin
         peak_monitor_cal_ff <= 1'b1;
      end else if (cal_done) begin
         peak_monitor_cal_ff <= 1'b0;
      end
   end

   // Calibration tick counter, restarted on every start
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cal_cnt_ff <= '0;
      end else if (cal_start) begin
         cal_cnt_ff <= '0;
      end else if ((state_ff == DCP_ST_CAL) && tick_en) begin
         cal_cnt_ff <= cal_cnt_ff + 16'h0001;
      end
   end

   // Demand clamped to [off, period] so the off time always fits
   always_comb begin
      off_ticks = {3'b000, min_off_code_ff} + MIN_OFF_BASE;
      if (pw_demand < off_ticks) begin
         nxt_pw = off_ticks;
      end else if (pw_demand > converter_period_code_ff) begin
         nxt_pw = converter_period_code_ff;
      end else begin
         nxt_pw = pw_demand;
      end
      nxt_on = nxt_pw - off_ticks;
   end

   // Period boundaries; period and off code change only between periods
   assign period_end = tick_en &&
      (tick_cnt_ff == act_period_ff - TICK_ONE);
   assign on_end = tick_en && (state_ff == DCP_ST_ON) &&
      (tick_cnt_ff + TICK_ONE >= act_on_ff);

   // Latch the new period's settings at its start
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         act_period_ff <= PERIOD_RESET;
         act_on_ff <= TICK_ZERO;
         pulse_width_code_ff <= SW_DELAY_RESET + MIN_OFF_BASE;
      end else if ((period_end && (state_ff != DCP_ST_CAL)) || cal_done) begin
         act_period_ff <= converter_period_code_ff;
         act_on_ff <= nxt_on;
         pulse_width_code_ff <= nxt_pw;
      end
   end

   // Next state of the switching sequence
   always_comb begin
      nxt_state = state_ff;
      nxt_tick_cnt = tick_cnt_ff;
      if (cal_start) begin
         // Drive goes off at once; a longer off time is always safe
         nxt_state = DCP_ST_CAL;
         nxt_tick_cnt = TICK_ZERO;
      end else begin
         case (state_ff)
            DCP_ST_ON: begin
               if (period_end) begin
                  nxt_tick_cnt = TICK_ZERO;
                  nxt_state = (nxt_on == TICK_ZERO) ? DCP_ST_OFF : DCP_ST_ON;
               end else if (on_end) begin
                  nxt_tick_cnt = tick_cnt_ff + TICK_ONE;
                  nxt_state = DCP_ST_OFF;
               end else if (tick_en) begin
                  nxt_tick_cnt = tick_cnt_ff + TICK_ONE;
               end
            end
            DCP_ST_OFF: begin
               if (period_end) begin
                  nxt_tick_cnt = TICK_ZERO;
                  nxt_state = (nxt_on == TICK_ZERO) ? DCP_ST_OFF : DCP_ST_ON;
               end else if (tick_en) begin
                  nxt_tick_cnt = tick_cnt_ff + TICK_ONE;
               end
            end
            DCP_ST_CAL: begin
               // Drive held off while the peak monitor is trimmed
               if (cal_done) begin
                  nxt_tick_cnt = TICK_ZERO;
                  nxt_state = (nxt_on == TICK_ZERO) ? DCP_ST_OFF : DCP_ST_ON;
               end
            end
            default: begin
               nxt_state = DCP_ST_OFF;
               nxt_tick_cnt = TICK_ZERO;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_ff <= DCP_ST_OFF;
         tick_cnt_ff <= TICK_ZERO;
      end else begin
         state_ff <= nxt_state;
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   // Pins straight from flops so they line up with the state
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         converter_drive_out_ff <= 1'b0;
         feedforward_pin_ff <= !FF_SAME_POLARITY;
      end else begin
         converter_drive_out_ff <= (nxt_state == DCP_ST_ON);
         feedforward_pin_ff <= (nxt_state == DCP_ST_ON) ~^
            FF_SAME_POLARITY;
      end
   end

   // Live current codes, sampled every cycle
   assign xtr_in[0] = xtr_four_current_in;
   assign xtr_in[1] = xtr_five_current_in;
   assign xtr_in[2] = xtr_six_current_in;

   generate
      for (genvar i = 0; i < NUM_XTR; i++) begin : g_xtr
         // Only the sense input updates these; bus writes cannot
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               xtr_current_ff[i] <= READ_IDLE;
            end else begin
               xtr_current_ff[i] <= xtr_in[i];
            end
         end
      end
   endgenerate

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         ADDR_XTR_FOUR: rd_mux = xtr_current_ff[0];
         ADDR_XTR_FIVE: rd_mux = xtr_current_ff[1];
         ADDR_XTR_SIX: rd_mux = xtr_current_ff[2];
         ADDR_PERIOD: rd_mux = converter_period_code_ff;
         ADDR_SW_DELAY: begin
            rd_mux = READ_IDLE;
            rd_mux[CAL_BIT] = peak_monitor_cal_ff;
            rd_mux[RSVD_BIT] = 1'b0;
            rd_mux[POL_BIT] = FF_SAME_POLARITY;
            rd_mux[MIN_OFF_MSB:0] = min_off_code_ff;
         end
         ADDR_PULSE_WIDTH: rd_mux = pulse_width_code_ff;
         default: rd_mux = READ_IDLE;
      endcase
   end

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata_ff <= READ_IDLE;
      end else if (reg_rd) begin
         reg_rdata_ff <= rd_mux;
      end else begin
         reg_rdata_ff <= READ_IDLE;
      end
   end

endmodule

// ===== tb/dcp_top_sva.sv
`timescale 1ns/1ps
module dcp_top_sva
   import dcp_pkg::*;
#(
   parameter logic FF_SAME_POLARITY = 1'b0,
   parameter logic [CAL_CNT_W-1:0] CAL_TICKS = 16'h0400
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   // Sense inputs and pins
   input wire logic [7:0] xtr_four_current_in,
   input wire logic [7:0] xtr_five_current_in,
   input wire logic converter_drive_out_ff,
   input wire logic feedforward_pin_ff,
   input wire logic peak_monitor_cal_ff
);
   localparam int CAL_T = int'(CAL_TICKS);
   localparam int CAL_MIN = 15 * (CAL_T - 1) - 2;
   localparam int CAL_MAX = 16 * CAL_T + 2;
   logic [15:0] cal_cnt_ff;
   logic [15:0] low_cnt_ff;
   // Cycles spent calibrating
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !peak_monitor_cal_ff) cal_cnt_ff <= 16'h0000;
      else cal_cnt_ff <= cal_cnt_ff + 16'h0001;
   end
   // Off run; saturated at reset so the first pulse is not a short off
   always_ff @(posedge sys_clk) begin
      if (!reset_n) low_cnt_ff <= 16'hFFFF;
      else if (converter_drive_out_ff) low_cnt_ff <= 16'h0000;
      else if (low_cnt_ff != 16'hFFFF) low_cnt_ff <= low_cnt_ff + 16'h0001;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence cal_req_s;
      reg_wr && reg_addr == ADDR_SW_DELAY && reg_wdata[CAL_BIT];
   endsequence
   sequence cal_run_s;
      peak_monitor_cal_ff && !converter_drive_out_ff;
   endsequence
   period_bit_six_a: assert property (
      reg_rd && reg_addr == ADDR_PERIOD |=> reg_rdata_ff[PERIOD_FIXED_BIT])
      else $error("period bit six read low");
   delay_fixed_bits_a: assert property (
      reg_rd && reg_addr == ADDR_SW_DELAY |=> !reg_rdata_ff[RSVD_BIT] &&
      reg_rdata_ff[POL_BIT] == FF_SAME_POLARITY)
      else $error("delay fixed bits wrong");
   four_current_a: assert property (
      reg_rd && reg_addr == ADDR_XTR_FOUR |=>
      reg_rdata_ff == $past(xtr_four_current_in, 2))
      else $error("transistor four current wrong");
   five_current_a: assert property (
      reg_rd && reg_addr == ADDR_XTR_FIVE |=>
      reg_rdata_ff == $past(xtr_five_current_in, 2))
      else $error("transistor five current wrong");
   ff_follows_a: assert property (
      feedforward_pin_ff == (converter_drive_out_ff ^ !FF_SAME_POLARITY))
      else $error("feed-forward polarity wrong");
   cal_start_a: assert property (
      cal_req_s ##0 !peak_monitor_cal_ff |=> cal_run_s)
      else $error("calibration did not start");
   cal_flag_read_a: assert property (
      reg_rd && reg_addr == ADDR_SW_DELAY |=>
      reg_rdata_ff[CAL_BIT] == $past(peak_monitor_cal_ff))
      else $error("calibration bit read wrong");
   cal_length_a: assert property (
      $fell(peak_monitor_cal_ff) |-> cal_cnt_ff >= CAL_MIN &&
      cal_cnt_ff <= CAL_MAX)
      else $error("calibration length wrong");
   cal_drive_off_a: assert property (
      peak_monitor_cal_ff |-> cal_run_s ##0 cal_cnt_ff <= CAL_MAX)
      else $error("drive on or overlong calibration");
   min_off_time_a: assert property (
      $rose(converter_drive_out_ff) |-> low_cnt_ff >= 16'h003A)
      else $error("off time below four ticks");
endmodule
bind dcp_top dcp_top_sva #(.FF_SAME_POLARITY(FF_SAME_POLARITY),
   .CAL_TICKS(CAL_TICKS)) dcp_top_sva_i (.sys_clk(sys_clk),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .xtr_four_current_in(xtr_four_current_in),
   .xtr_five_current_in(xtr_five_current_in),
   .converter_drive_out_ff(converter_drive_out_ff),
   .feedforward_pin_ff(feedforward_pin_ff),
   .peak_monitor_cal_ff(peak_monitor_cal_ff));

// ===== tb/dcp_xtr_model.sv
`timescale 1ns/1ps
module dcp_xtr_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Gate drive from the converter
   input wire logic drive_in,
   // Last measured on and off lengths, in clocks
   output logic [15:0] on_len_ff,
   output logic [15:0] off_len_ff
);
   logic [15:0] run_ff;
   logic drive_d_ff;
   // Length of each gate level, latched when the level flips
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         run_ff <= 16'h0000;
         drive_d_ff <= 1'b0;
         on_len_ff <= 16'h0000;
         off_len_ff <= 16'h0000;
      end else begin
         drive_d_ff <= drive_in;
         run_ff <= (drive_in != drive_d_ff) ? 16'h0001 : run_ff + 16'h0001;
         if (drive_in != drive_d_ff && drive_d_ff) on_len_ff <= run_ff;
         if (drive_in != drive_d_ff && !drive_d_ff) off_len_ff <= run_ff;
      end
   end
endmodule

// ===== tb/dcp_top_test.sv
`timescale 1ns/1ps
module dcp_top_test
   import dcp_pkg::*;
;
   logic sys_clk, reset_n, reg_wr, reg_rd, drv, ffp, cal, hi, fl;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, x4, x5, x6, pw_demand;
   logic [15:0] on_len, off_len;
   int num_errors, checks, n, per;
   logic [7:0] ro_a[5] = '{8'h57, 8'h58, 8'h59, 8'h5E, 8'h5A};
   logic [7:0] ro_e[5] = '{8'h00, 8'hFF, 8'h5A, 8'h18, 8'h00};
   logic [7:0] pw_w[3] = '{8'h00, 8'hBF, 8'h80};
   logic [7:0] pw_e[3] = '{8'h40, 8'hFF, 8'hC0};
   logic [7:0] dly[3] = '{8'h0A, 8'h1F, 8'h00};
   logic [7:0] dem[3] = '{8'h30, 8'hFF, 8'h02};
   logic [7:0] pw_x[3] = '{8'h30, 8'hFF, 8'h04};
   int on_t[3] = '{34, 220, 0};
   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;
   dcp_top #(.CAL_TICKS(16'h0004)) dcp_top_i (.sys_clk(sys_clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .xtr_four_current_in(x4), .xtr_five_current_in(x5),
      .xtr_six_current_in(x6), .pw_demand(pw_demand),
      .converter_drive_out_ff(drv), .feedforward_pin_ff(ffp),
      .peak_monitor_cal_ff(cal));
   dcp_xtr_model dcp_xtr_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .drive_in(drv), .on_len_ff(on_len), .off_len_ff(off_len));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (num_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Read data stand only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check({8'h00, reg_rdata_ff}, {8'h00, e});
      @(posedge sys_clk);
   endtask
   // Tick jitter allowed two clocks either way; a one-tick error still trips
   task near(input logic [15:0] seen, input int ticks);
      int e;
      e = ticks * 61035 / 4000;
      check({15'h0000, int'(seen) + 2 >= e && int'(seen) <= e + 2}, 16'h0001);
   endtask
   initial begin
      {sys_clk, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {x4, x5, x6, pw_demand} = {8'h00, 8'hFF, 8'h5A, 8'h30};
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(ADDR_PERIOD, PERIOD_RESET);
      rd_chk(ADDR_SW_DELAY, SW_DELAY_RESET);
      for (int i = 0; i < 5; i++) begin
         wr_reg(ro_a[i], 8'hA5);
         rd_chk(ro_a[i], ro_e[i]);
      end
      x4 <= 8'h3C;
      x6 <= 8'hC3;
      repeat (2) @(posedge sys_clk);
      rd_chk(ADDR_XTR_FOUR, 8'h3C);
      rd_chk(ADDR_XTR_SIX, 8'hC3);
      wr_reg(ADDR_SW_DELAY, 8'h6A);
      rd_chk(ADDR_SW_DELAY, 8'h0A);
      // Settings apply only from the next period, so wait one out first
      for (int i = 0; i < 3; i++) begin
         wr_reg(ADDR_PERIOD, pw_w[i]);
         rd_chk(ADDR_PERIOD, pw_e[i]);
         wr_reg(ADDR_SW_DELAY, dly[i]);
         pw_demand <= dem[i];
         per = int'(pw_e[i]);
         hi = 1'b0;
         fl = 1'b0;
         repeat (4100 + 16 * per) @(posedge sys_clk);
         // Feed-forward must mirror the drive inverted on every cycle
         repeat (16 * per) begin
            @(posedge sys_clk);
            hi = hi | drv;
            fl = fl | (ffp === drv);
         end
         rd_chk(ADDR_PULSE_WIDTH, pw_x[i]);
         check({15'h0000, fl}, 16'h0000);
         if (on_t[i] == 0) check({15'h0000, hi}, 16'h0000);
         else begin
            near(on_len, on_t[i]);
            near(off_len, per - on_t[i]);
            near(on_len + off_len, per);
         end
      end
      wr_reg(ADDR_SW_DELAY, 8'h80);
      rd_chk(ADDR_SW_DELAY, 8'h80);
      // Flag read at the edge shows the value launched one edge earlier
      n = 0;
      while (cal !== 1'b0 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 200) begin
         num_errors++;
      end else begin
         rd_chk(ADDR_SW_DELAY, 8'h00);
         reset_n <= 1'b0;
         repeat (2) @(posedge sys_clk);
         reset_n <= 1'b1;
         rd_chk(ADDR_PERIOD, PERIOD_RESET);
      end
      final_report;
   end
endmodule
